// ===== verilog/rxim_pkg.sv
package rxim_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [11:0] MASK_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] GLOBAL_OFFSET = 12'h008;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int GLOBAL_BIT = 0;
	localparam int FLAG_LSB = 1;
	localparam int FLAG_MSB = 10;
	localparam int FLAG_COUNT = FLAG_MSB - FLAG_LSB + 1;
	localparam int CRC_BIT = 1;
	localparam int OVERFLOW_BIT = 2;
	localparam int TOO_LONG_BIT = 3;
	localparam int GOOD_BIT = 4;
	localparam int ALIGN_BIT = 5;
	localparam int RUNT_BIT = 6;
	localparam int MISSED_BIT = 7;
	localparam int MAX_LEN_BIT = 8;
	localparam int EARLY_BIT = 9;
	localparam int DESC_BIT = 10;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and writable field mask
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] FIELD_MASK = 32'h0000_07FF;

endpackage

// ===== verilog/rxim_top.sv
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module rxim_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crc_error_flag_evt,
	input wire logic rx_fifo_overflow_flag_evt,
	input wire logic packet_too_long_flag_evt,
	input wire logic rx_good_flag_evt,
	input wire logic align_error_flag_evt,
	input wire logic runt_packet_flag_evt,
	input wire logic more_missed_packets_flag_evt,
	input wire logic max_length_exceeded_flag_evt,
	input wire logic dma_early_notice_flag_evt,
	input wire logic rx_descriptor_unavailable_flag_evt,
	output logic rx_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Block overview
	// Ten receive flags latch events from the receive path.
	// Each flag sits at the same bit in the status word and the mask word.
	// Mask bit 0 is the receive global enable, not a flag enable.
	// Status bit 0 reads the summary of enabled flags before the global enable, so software can poll it.
	// The interrupt line is the summary qualified by the global enable.
	//
	// Flag map, status and mask share the layout:
	//   bit 10  descriptor unavailable
	//   bit 9   DMA early notice
	//   bit 8   maximum length exceeded
	//   bit 7   more missed packets
	//   bit 6   runt packet
	//   bit 5   alignment error
	//   bit 4   receive good
	//   bit 3   packet too long
	//   bit 2   receive FIFO overflow
	//   bit 1   CRC error
	//   bit 0   global enable (mask) / summary (status)
	//
	// Register map:
	//   mask word   read and write, upper bits read zero
	//   status word write one to clear, bit 0 read only
	//   any other   error answer, read data zero, writes dropped
	//
	// Timing seen from the bus:
	//   setup cycle registered, answer one cycle later
	//   write lands at the access edge
	//   interrupt follows a landed write one edge later
	//
	// Limitations:
	//   no transmit side, that lives in a sibling block
	//   no wait states, pready is high in the first access cycle
	//   events are sampled as synchronous levels

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [31:0] mask_q;
	logic [rxim_pkg::FLAG_MSB:rxim_pkg::FLAG_LSB] flag_q;
	logic [31:0] status_rd;
	logic [31:0] evt;
	logic [31:0] enabled;
	logic setup;
	logic access;
	logic wr_mask;
	logic wr_status;
	logic hit;
	logic [31:0] rd_d;
	logic rx_summary_flag;
	logic [31:0] wbytes;

	////////////////////////////////////////////////////////////////////////////////
	// Event vector in status layout; global bit has no source
	always_comb begin
		evt = 32'h0000_0000;
		evt[rxim_pkg::CRC_BIT] = crc_error_flag_evt;
		evt[rxim_pkg::OVERFLOW_BIT] = rx_fifo_overflow_flag_evt;
		evt[rxim_pkg::TOO_LONG_BIT] = packet_too_long_flag_evt;
		evt[rxim_pkg::GOOD_BIT] = rx_good_flag_evt;
		evt[rxim_pkg::ALIGN_BIT] = align_error_flag_evt;
		evt[rxim_pkg::RUNT_BIT] = runt_packet_flag_evt;
		evt[rxim_pkg::MISSED_BIT] = more_missed_packets_flag_evt;
		evt[rxim_pkg::MAX_LEN_BIT] = max_length_exceeded_flag_evt;
		evt[rxim_pkg::EARLY_BIT] = dma_early_notice_flag_evt;
		evt[rxim_pkg::DESC_BIT] = rx_descriptor_unavailable_flag_evt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB decode; no-wait answer from a registered pready, so outputs stay registered
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign wr_mask = access && pwrite && (paddr == rxim_pkg::MASK_OFFSET);
	assign wr_status = access && pwrite && (paddr == rxim_pkg::STATUS_OFFSET);
	assign hit = (paddr == rxim_pkg::MASK_OFFSET) || (paddr == rxim_pkg::STATUS_OFFSET);

	// Byte strobes expanded to bit lanes
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wbytes[i*8 +: 8] = {8{pstrb[i]}};
		end
	end

	// Pready high in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Read mux and error answer, latched at setup
	always_comb begin
		rd_d = 32'h0000_0000;
		if (paddr == rxim_pkg::MASK_OFFSET) begin
			rd_d = mask_q;
		end else if (paddr == rxim_pkg::STATUS_OFFSET) begin
			rd_d = status_rd | {31'h0000_0000, rx_summary_flag};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr <= !hit;
		end else begin
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Enable mask: bits 10..1 per flag, bit 0 global; upper bits read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= rxim_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= ((mask_q & ~wbytes) | (pwdata & wbytes)) & rxim_pkg::FIELD_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky flags, one per bit; a new event beats a same-cycle clear
	// Losing an event to a clear would hide a frame from software
	genvar g;
	generate
		for (g = rxim_pkg::FLAG_LSB; g <= rxim_pkg::FLAG_MSB; g++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag_q[g] <= rxim_pkg::STATUS_RESET[g];
				end else if (evt[g]) begin
					flag_q[g] <= 1'b1;
				end else if (wr_status && wbytes[g] && pwdata[g]) begin
					flag_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Status word view; unused positions read zero
	always_comb begin
		status_rd = 32'h0000_0000;
		status_rd[rxim_pkg::FLAG_MSB:rxim_pkg::FLAG_LSB] = flag_q;
	end

	// Flag participates only when its enable is one
	always_comb begin
		enabled = status_rd & mask_q;
		enabled[rxim_pkg::GLOBAL_BIT] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-flag gating only; the global enable is applied later, at rx_irq
	always_comb begin
		rx_summary_flag = 1'b0;
		if (enabled[rxim_pkg::DESC_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::EARLY_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::MAX_LEN_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::MISSED_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::RUNT_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::ALIGN_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::GOOD_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::TOO_LONG_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::OVERFLOW_BIT]) rx_summary_flag = 1'b1;
		if (enabled[rxim_pkg::CRC_BIT]) rx_summary_flag = 1'b1;
	end

	// Level output, registered; global bit 0 qualifies all flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_irq <= 1'b0;
		end else begin
			rx_irq <= rx_summary_flag && mask_q[rxim_pkg::GLOBAL_BIT];
		end
	end

endmodule
`default_nettype wire

// ===== sim/rxim_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rxim_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_irq
);
	// Committed write; only writes may mask or clear the level
	wire wr = psel && penable && pready && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("setup unanswered");
	property p_acc; psel && penable |-> pready; endproperty
	a_acc: assert property (p_acc) else $error("access waits");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_idle; !psel |=> !pready; endproperty
	a_idle: assert property (p_idle) else $error("ready unasked");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("lone error");
	property p_rd0; pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("error data");
	property p_fall; $fell(rx_irq) |-> $past(wr, 2); endproperty
	a_fall: assert property (p_fall) else $error("irq dropped");
	property p_hold; rx_irq && !wr && !$past(wr) |=> rx_irq; endproperty
	a_hold: assert property (p_hold) else $error("irq not level");
endmodule
bind rxim_top rxim_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
	.pslverr, .rx_irq);
`default_nettype wire

// ===== sim/rxim_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module rxim_cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rx_irq,
	output var int taken
);
	logic seen_q;
	// Level input, so each rise is taken once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 1'b0;
			taken <= 0;
		end else begin
			seen_q <= rx_irq;
			taken <= taken + int'(rx_irq && !seen_q);
		end
	end
endmodule
`default_nettype wire

// ===== sim/rxim_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rxim_top_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [9:0] evt = 10'h0;
	logic [3:0] strb = 4'hF;
	logic pready, pslverr, rx_irq, err;
	int mismatches = 0, checks = 0, cycles = 0, taken;
	always #4 pclk = ~pclk;
	rxim_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(strb),
		.prdata, .pready, .pslverr, .rx_irq, .crc_error_flag_evt(evt[0]),
		.rx_fifo_overflow_flag_evt(evt[1]), .packet_too_long_flag_evt(evt[2]),
		.rx_good_flag_evt(evt[3]), .align_error_flag_evt(evt[4]), .runt_packet_flag_evt(evt[5]),
		.more_missed_packets_flag_evt(evt[6]), .max_length_exceeded_flag_evt(evt[7]),
		.dma_early_notice_flag_evt(evt[8]), .rx_descriptor_unavailable_flag_evt(evt[9]));
	rxim_cpu_model i_cpu (.pclk, .presetn, .rx_irq, .taken);
	// Hang guard
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			end_sim;
		end
	end
	////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// Idle edge after release, so no strobe is set twice in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		apb(1'b0, rxim_pkg::MASK_OFFSET, 32'h0);
		chk(rd, rxim_pkg::MASK_RESET);
		apb(1'b1, rxim_pkg::MASK_OFFSET, 32'hFFFF_FFFF);
		apb(1'b0, rxim_pkg::MASK_OFFSET, 32'h0);
		chk(rd, rxim_pkg::FIELD_MASK);
		apb(1'b0, 12'h00C, 32'h0);
		chk({err, rd}, 33'h1_0000_0000);
	endtask
	// One flag: global off, global on, other bits only, then cleared
	task t_bit(input int b);
		logic [31:0] m;
		m = 32'h1 << b;
		apb(1'b1, rxim_pkg::MASK_OFFSET, m);
		evt <= 10'(m >> 1);
		@(posedge pclk);
		evt <= 10'h0;
		repeat (2) @(posedge pclk);
		chk(rx_irq, 1'b0);
		apb(1'b1, rxim_pkg::MASK_OFFSET, m | 32'h1);
		@(posedge pclk);
		chk(rx_irq, 1'b1);
		apb(1'b0, rxim_pkg::STATUS_OFFSET, 32'h0);
		chk(rd, m | 32'h1);
		apb(1'b1, rxim_pkg::MASK_OFFSET, rxim_pkg::FIELD_MASK ^ m);
		@(posedge pclk);
		chk(rx_irq, 1'b0);
		apb(1'b1, rxim_pkg::STATUS_OFFSET, m);
		apb(1'b1, rxim_pkg::MASK_OFFSET, m | 32'h1);
		@(posedge pclk);
		chk(rx_irq, 1'b0);
	endtask
	// Lane masking, set beating clear, and a reset in mid-run
	task t_edge;
		strb <= 4'hE;
		apb(1'b1, rxim_pkg::MASK_OFFSET, rxim_pkg::FIELD_MASK);
		strb <= 4'hF;
		apb(1'b0, rxim_pkg::MASK_OFFSET, 32'h0);
		chk(rd, 32'h0000_0701);
		fork
			apb(1'b1, rxim_pkg::STATUS_OFFSET, 32'h0000_0002);
			begin
				@(posedge pclk);
				evt <= 10'h001;
				@(posedge pclk);
				evt <= 10'h0;
			end
		join
		apb(1'b0, rxim_pkg::STATUS_OFFSET, 32'h0);
		chk(rd, 32'h0000_0002);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, rxim_pkg::STATUS_OFFSET, 32'h0);
		chk(rd, rxim_pkg::STATUS_RESET);
		apb(1'b0, rxim_pkg::MASK_OFFSET, 32'h0);
		chk(rd, rxim_pkg::MASK_RESET);
		chk(rx_irq, 1'b0);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		for (int b = rxim_pkg::FLAG_LSB; b <= rxim_pkg::FLAG_MSB; b++) begin
			t_bit(b);
		end
		chk(33'(taken), 33'hA);
		t_edge;
		end_sim;
	end
endmodule
`default_nettype wire
